// ===== design/lamp_driver.sv
// turns per-lamp state codes into lamp levels with a common flash clock
`include "run_alarm_map.svh"

module lamp_driver #(
	parameter int unsigned FLASH_HALF_CYC = 62500000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input run_alarm_pkg::lamp_pair_t lamps_i,
	output logic run_lamp_o,
	output logic run_key_lamp_o,
	output logic alarm_lamp_o
);
	import run_alarm_pkg::*;

	localparam logic [31:0] HALF_LAST = 32'(FLASH_HALF_CYC - 1);

	logic [31:0] flash_cnt;
	logic flash_phase;

	wire flash_wrap = (flash_cnt >= HALF_LAST);
	wire [31:0] next_flash_cnt = flash_wrap ? 32'h0 : flash_cnt + 32'h1;

	function automatic logic lamp_level(input lamp_state_t s, input logic phase);
		case (s)
			LAMP_ON: lamp_level = 1'b1;
			LAMP_FLASH: lamp_level = phase;
			default: lamp_level = 1'b0;
		endcase
	endfunction

	wire next_run = lamp_level(lamps_i.run, flash_phase);
	wire next_alarm = lamp_level(lamps_i.alarm, flash_phase);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_cnt <= 32'h0;
			flash_phase <= 1'b0;
		end else if (ce_i) begin
			flash_cnt <= next_flash_cnt;
			if (flash_wrap) begin
				flash_phase <= ~flash_phase;
			end
		end
	end

	// key lamp and face lamp share one source so they can never disagree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_lamp_o <= 1'b0;
			run_key_lamp_o <= 1'b0;
			alarm_lamp_o <= 1'b0;
		end else if (ce_i) begin
			run_lamp_o <= next_run;
			run_key_lamp_o <= next_run;
			alarm_lamp_o <= next_alarm;
		end
	end

endmodule

// ===== design/run_alarm_indicator_control.sv
// status indication, fault reset qualification and run interlock of the keypad panel
//
// What this block does
// - lamps follow single highest active priority
// - run key lamp mirrors face run lamp
// - not ready or unpowered: priority one
// - fault lights alarm, priority two
// - stop key on terminals, estop alarm: three
// - estop fault priority four, then fault
// - run with external baseblock: priority six
// - running incl. low freq, start braking: eight
// - decelerating or stop braking: priority nine
// - reset or stop key clears fault
// - reset ignored while operation signal active
// - display key cycles function indicators
// - programming selected then stop: program mode
// - program mode blocks run unless access five
// - access five accepts run during editing
`include "run_alarm_map.svh"

module run_alarm_indicator_control #(
	parameter int unsigned FLASH_HALF_CYC = `FLASH_HALF_MS * `CLK_KHZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input run_alarm_pkg::drive_cond_t cond_i,
	input wire logic fault_detect_i,
	input wire logic fault_reset_i,
	input wire logic stop_key_i,
	input wire logic terminal_op_i,
	input wire logic operation_i,
	input wire logic run_cmd_i,
	input wire logic display_select_key_i,
	input wire logic editing_i,
	input wire logic [3:0] access_select_constant_i,
	output logic run_lamp_o,
	output logic run_key_lamp_o,
	output logic alarm_lamp_o,
	output logic [3:0] priority_o,
	output logic fault_latched_o,
	output run_alarm_pkg::func_sel_t func_sel_o,
	output logic program_mode_o,
	output logic run_accept_o
);
	import run_alarm_pkg::*;

	logic fault;
	logic estop_key;
	logic stop_key_prev;
	logic dsel_prev;
	logic op_prev;
	logic prog_during_op;
	op_mode_t mode;
	func_sel_t func_sel;
	lamp_pair_t lamps;

	// key presses are levels from the panel; act on the press edge only
	wire stop_press = stop_key_i & ~stop_key_prev;
	wire dsel_press = display_select_key_i & ~dsel_prev;
	wire op_fall = op_prev & ~operation_i;

	function automatic func_sel_t next_func(input func_sel_t f);
		case (f)
			FN_FREQ_REF: next_func = FN_OUT_FREQ;
			FN_OUT_FREQ: next_func = FN_OUT_CURR;
			FN_OUT_CURR: next_func = FN_MONITOR;
			FN_MONITOR: next_func = FN_DIRECTION;
			FN_DIRECTION: next_func = FN_LOC_REM;
			FN_LOC_REM: next_func = FN_PROGRAM;
			default: next_func = FN_FREQ_REF;
		endcase
	endfunction

	// functions that change settings rather than watch the drive
	function automatic logic is_prog_func(input func_sel_t f);
		is_prog_func = (f == FN_DIRECTION) || (f == FN_LOC_REM) || (f == FN_PROGRAM);
	endfunction

	// one entry per priority from two to nine, run lamp first; other codes, not ready included, leave both lamps dark
	function automatic lamp_pair_t pattern(input logic [3:0] p);
		lamp_pair_t lp;
		lp = '{run: LAMP_OFF, alarm: LAMP_OFF};
		case (p)
			`PRIO_FAULT: begin
				lp.run = LAMP_OFF;
				lp.alarm = LAMP_ON;
			end
			`PRIO_ESTOP_RUN: begin
				lp.run = LAMP_FLASH;
				lp.alarm = LAMP_FLASH;
			end
			`PRIO_ESTOP_FAULT: begin
				lp.run = LAMP_FLASH;
				lp.alarm = LAMP_ON;
			end
			`PRIO_ALARM_STOP: begin
				lp.run = LAMP_OFF;
				lp.alarm = LAMP_FLASH;
			end
			`PRIO_ALARM_RUN: begin
				lp.run = LAMP_ON;
				lp.alarm = LAMP_FLASH;
			end
			`PRIO_BASEBLOCK: begin
				lp.run = LAMP_FLASH;
				lp.alarm = LAMP_OFF;
			end
			`PRIO_RUNNING: begin
				lp.run = LAMP_ON;
				lp.alarm = LAMP_OFF;
			end
			`PRIO_DECEL: begin
				lp.run = LAMP_FLASH;
				lp.alarm = LAMP_OFF;
			end
			default: lp = '{run: LAMP_OFF, alarm: LAMP_OFF};
		endcase
		pattern = lp;
	endfunction

	// fault latch: set wins over clear so a fault in the reset cycle survives
	wire estop_fault_stopped = cond_i.estop_fault & cond_i.stopped;
	wire fault_set = fault_detect_i | estop_fault_stopped;
	wire fault_clear = (fault_reset_i | stop_press) & ~operation_i;
	wire next_fault = fault_set | (fault & ~fault_clear);

	// stop key while the terminals run the drive is an emergency stop
	wire estop_key_set = stop_press & terminal_op_i & ~cond_i.stopped;
	wire estop_key_clear = cond_i.stopped & ~run_cmd_i;
	wire next_estop_key = estop_key_set | (estop_key & ~estop_key_clear);

	// condition terms in priority order
	wire c_not_ready = ~cond_i.ready;
	wire c_fault = fault;
	wire c_estop_any = estop_key | cond_i.estop_alarm;
	wire c_estop_run = c_estop_any & ~cond_i.stopped;
	wire c_estop_fault = cond_i.estop_fault & ~cond_i.stopped;
	wire c_alarm_stop = (cond_i.alarm | c_estop_any) & cond_i.stopped;
	wire c_alarm_run = run_cmd_i & cond_i.ext_baseblock;
	wire c_baseblock = cond_i.baseblock & cond_i.stopped;
	wire c_running = cond_i.running | cond_i.below_min_freq | cond_i.dc_brake_start;
	wire c_decel = cond_i.decel | cond_i.dc_brake_stop;

	wire [3:0] next_prio = c_not_ready ? `PRIO_NOT_READY :
		c_fault ? `PRIO_FAULT :
		c_estop_run ? `PRIO_ESTOP_RUN :
		c_estop_fault ? `PRIO_ESTOP_FAULT :
		c_alarm_stop ? `PRIO_ALARM_STOP :
		c_alarm_run ? `PRIO_ALARM_RUN :
		c_baseblock ? `PRIO_BASEBLOCK :
		c_running ? `PRIO_RUNNING :
		c_decel ? `PRIO_DECEL :
		`PRIO_NONE;

	// combinational pattern, so the lamp flops follow a change one cycle later
	wire lamp_pair_t next_lamps = pattern(next_prio);

	// mode tracking for the restart interlock
	wire prog_sel = is_prog_func(func_sel);
	wire next_prog_during_op = operation_i & (prog_sel | prog_during_op);
	wire enter_program = op_fall & prog_during_op;
	wire leave_program = ~prog_sel & ~operation_i;

	// editing blocks a start unless the access value opens it; a hazard the operator owns
	wire access_open = (access_select_constant_i == `ACCESS_RUN_ANYTIME);
	wire run_blocked = (mode == MODE_PROGRAM) | editing_i;
	wire next_run_accept = run_cmd_i & (~run_blocked | access_open);

	// history flops reset to the idle key level so no false press follows reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stop_key_prev <= 1'b0;
		end else if (ce_i) begin
			stop_key_prev <= stop_key_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dsel_prev <= 1'b0;
		end else if (ce_i) begin
			dsel_prev <= display_select_key_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_prev <= 1'b0;
		end else if (ce_i) begin
			op_prev <= operation_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault <= `FAULT_RESET;
		end else if (ce_i) begin
			fault <= next_fault;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			estop_key <= 1'b0;
		end else if (ce_i) begin
			estop_key <= next_estop_key;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			func_sel <= FN_FREQ_REF;
		end else if (ce_i && dsel_press) begin
			func_sel <= next_func(func_sel);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prog_during_op <= 1'b0;
		end else if (ce_i) begin
			prog_during_op <= next_prog_during_op;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= MODE_DRIVE;
		end else if (ce_i) begin
			case (mode)
				MODE_DRIVE: begin
					if (enter_program) begin
						mode <= MODE_PROGRAM;
					end
				end
				MODE_PROGRAM: begin
					if (leave_program) begin
						mode <= MODE_DRIVE;
					end
				end
				default: mode <= MODE_DRIVE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			priority_o <= `PRIO_RESET;
		end else if (ce_i) begin
			priority_o <= next_prio;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lamps <= '{run: LAMP_OFF, alarm: LAMP_OFF};
		end else if (ce_i) begin
			lamps <= next_lamps;
		end
	end

	// copy of the latch taken from the same next value, so both agree every cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_latched_o <= `FAULT_RESET;
		end else if (ce_i) begin
			fault_latched_o <= next_fault;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			func_sel_o <= FN_FREQ_REF;
		end else if (ce_i) begin
			func_sel_o <= dsel_press ? next_func(func_sel) : func_sel;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			program_mode_o <= 1'b0;
		end else if (ce_i) begin
			program_mode_o <= (mode == MODE_PROGRAM);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_accept_o <= 1'b0;
		end else if (ce_i) begin
			run_accept_o <= next_run_accept;
		end
	end

	lamp_driver #(
		.FLASH_HALF_CYC(FLASH_HALF_CYC)
	) u_lamps (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.lamps_i(lamps),
		.run_lamp_o(run_lamp_o),
		.run_key_lamp_o(run_key_lamp_o),
		.alarm_lamp_o(alarm_lamp_o)
	);

endmodule

// ===== design/run_alarm_map.svh
// constants for the run/alarm indicator control block
`ifndef RUN_ALARM_MAP_SVH
`define RUN_ALARM_MAP_SVH

// indication priorities, 1 is most important; 0 means nothing to show
`define PRIO_NONE 4'h0
`define PRIO_NOT_READY 4'h1
`define PRIO_FAULT 4'h2
`define PRIO_ESTOP_RUN 4'h3
`define PRIO_ESTOP_FAULT 4'h4
`define PRIO_ALARM_STOP 4'h5
`define PRIO_ALARM_RUN 4'h6
`define PRIO_BASEBLOCK 4'h7
`define PRIO_RUNNING 4'h8
`define PRIO_DECEL 4'h9

// access-select value that lets a run command through in program mode
`define ACCESS_RUN_ANYTIME 4'h5
`define ACCESS_RESET 4'h0

// flash timing: half period in milliseconds at the system clock rate
`define CLK_KHZ 250000
`define FLASH_HALF_MS 250

// reset values
`define PRIO_RESET 4'h1
`define FAULT_RESET 1'b0

`endif

// ===== design/run_alarm_pkg.sv
// types for the run/alarm indicator control block
package run_alarm_pkg;

	// per-lamp drive code
	typedef enum logic [1:0] {
		LAMP_OFF,
		LAMP_ON,
		LAMP_FLASH
	} lamp_state_t;

	typedef struct packed {
		lamp_state_t run;
		lamp_state_t alarm;
	} lamp_pair_t;

	// function indicators in display-select order
	typedef enum logic [2:0] {
		FN_FREQ_REF,
		FN_OUT_FREQ,
		FN_OUT_CURR,
		FN_MONITOR,
		FN_DIRECTION,
		FN_LOC_REM,
		FN_PROGRAM
	} func_sel_t;

	typedef enum logic {
		MODE_DRIVE,
		MODE_PROGRAM
	} op_mode_t;

	// drive conditions reported by the rest of the drive
	typedef struct packed {
		logic ready;
		logic estop_alarm;
		logic estop_fault;
		logic alarm;
		logic ext_baseblock;
		logic baseblock;
		logic running;
		logic below_min_freq;
		logic dc_brake_start;
		logic decel;
		logic dc_brake_stop;
		logic stopped;
	} drive_cond_t;

endpackage

// ===== verif/keypad_partner.sv
// keypad operator model: presses and releases the stop and display keys
module keypad_partner (
	input wire logic clk_i,
	output logic stop_key_o,
	output logic display_select_key_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		stop_key_o = 1'b0;
		display_select_key_o = 1'b0;
	end
	// key released between presses, the block only sees rising edges
	task automatic press(input bit stop);
		@(posedge clk_i);
		if (stop) stop_key_o <= 1'b1;
		else display_select_key_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		stop_key_o <= 1'b0;
		display_select_key_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
endmodule

// ===== verif/run_alarm_indicator_control_assertions.sv
// port-level checks of the run/alarm indicator block
module run_alarm_indicator_control_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input run_alarm_pkg::drive_cond_t cond_i,
	input wire logic fault_detect_i,
	input wire logic fault_reset_i,
	input wire logic operation_i,
	input wire logic run_cmd_i,
	input wire logic [3:0] access_select_constant_i,
	input wire logic run_lamp_o,
	input wire logic run_key_lamp_o,
	input wire logic alarm_lamp_o,
	input wire logic [3:0] priority_o,
	input wire logic fault_latched_o,
	input wire logic run_accept_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_key; run_key_lamp_o == run_lamp_o; endproperty
	a_key: assert property (p_key) else $error("run key lamp differs");
	property p_nrdy; ce_i && !cond_i.ready |=> priority_o == 4'h1; endproperty
	a_nrdy: assert property (p_nrdy) else $error("not ready not shown");
	property p_flt; ce_i && fault_latched_o && cond_i.ready |=> priority_o == 4'h2; endproperty
	a_flt: assert property (p_flt) else $error("fault priority wrong");
	property p_alm; ce_i && priority_o == 4'h2 |=> alarm_lamp_o && !run_lamp_o; endproperty
	a_alm: assert property (p_alm) else $error("fault lamps wrong");
	property p_run; ce_i && priority_o == 4'h8 |=> run_lamp_o && !alarm_lamp_o; endproperty
	a_run: assert property (p_run) else $error("running lamps wrong");
	property p_hold; ce_i && fault_latched_o && operation_i |=> fault_latched_o; endproperty
	a_hold: assert property (p_hold) else $error("fault cleared in operation");
	// set wins over reset, so both set causes are excluded
	property p_clr;
		ce_i && fault_latched_o && fault_reset_i && !operation_i && !fault_detect_i
			&& !cond_i.estop_fault |=> !fault_latched_o;
	endproperty
	a_clr: assert property (p_clr) else $error("fault not cleared");
	property p_acc; ce_i && run_cmd_i && access_select_constant_i == 4'h5 |=> run_accept_o;
	endproperty
	a_acc: assert property (p_acc) else $error("run refused at access five");
endmodule

bind run_alarm_indicator_control run_alarm_indicator_control_checker u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cond_i(cond_i),
	.fault_detect_i(fault_detect_i), .fault_reset_i(fault_reset_i),
	.operation_i(operation_i), .run_cmd_i(run_cmd_i),
	.access_select_constant_i(access_select_constant_i), .run_lamp_o(run_lamp_o),
	.run_key_lamp_o(run_key_lamp_o), .alarm_lamp_o(alarm_lamp_o),
	.priority_o(priority_o), .fault_latched_o(fault_latched_o), .run_accept_o(run_accept_o));

// ===== verif/test_run_alarm_indicator_control.sv
// self-checking bench of the run/alarm indicator block
module test_run_alarm_indicator_control;
	timeunit 1ns;
	timeprecision 1ps;
	import run_alarm_pkg::*;
	logic clk_i = 0, rst_i = 1, ce_i = 1, fdet = 0, frst = 0, top = 0, op = 0, run = 0, edit = 0;
	logic stop_k, dsp_k, rl, rkl, al, flt, pm, acc;
	logic [3:0] access = 4'h0, prio;
	drive_cond_t cond = '0;
	func_sel_t fsel;
	int mismatches = 0, n_tests = 0;
	run_alarm_indicator_control #(.FLASH_HALF_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .cond_i(cond), .fault_detect_i(fdet), .fault_reset_i(frst),
		.stop_key_i(stop_k), .terminal_op_i(top), .operation_i(op), .run_cmd_i(run),
		.display_select_key_i(dsp_k), .editing_i(edit), .access_select_constant_i(access),
		.run_lamp_o(rl), .run_key_lamp_o(rkl), .alarm_lamp_o(al), .priority_o(prio),
		.fault_latched_o(flt), .func_sel_o(fsel), .program_mode_o(pm), .run_accept_o(acc));
	keypad_partner kp (.clk_i(clk_i), .stop_key_o(stop_k), .display_select_key_o(dsp_k));
	initial forever #2 clk_i = ~clk_i;
	task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic setc(input logic r, input logic [11:0] c);
		@(posedge clk_i);
		run <= r;
		cond <= drive_cond_t'(c);
		wt(3);
	endtask
	task automatic t_prio;
		logic v;
		setc(0, 12'h000); chk("prio", prio, 4'h1);
		chk("lamps", {rl, rkl, al}, 3'h0);
		setc(0, 12'h820); chk("prio", prio, 4'h8);
		chk("lamps", {rl, rkl, al}, 3'h6);
		setc(0, 12'h810); chk("prio", prio, 4'h8);
		setc(0, 12'h808); chk("prio", prio, 4'h8);
		setc(0, 12'h824); chk("prio", prio, 4'h8);
		setc(0, 12'h804); chk("prio", prio, 4'h9);
		setc(0, 12'h802); chk("prio", prio, 4'h9);
		setc(0, 12'h841); chk("prio", prio, 4'h7);
		setc(1, 12'h880); chk("prio", prio, 4'h6);
		setc(0, 12'h941); chk("prio", prio, 4'h5);
		setc(0, 12'hC01); chk("prio", prio, 4'h5);
		setc(0, 12'hA20); chk("prio", prio, 4'h4);
		setc(0, 12'hC20); chk("prio", prio, 4'h3);
		// both lamps flash in one phase, which flips every four cycles
		v = rl;
		chk("flash", {rl, al}, {v, v});
		wt(4); chk("flash", {rl, al}, {~v, ~v});
		wt(4); chk("flash", {rl, al}, {v, v});
	endtask
	task automatic t_fault;
		setc(0, 12'hA01); chk("flt", flt, 1'b1);
		chk("prio", prio, 4'h2);
		setc(0, 12'h800); @(posedge clk_i); fdet <= 1; op <= 1; frst <= 1;
		@(posedge clk_i); fdet <= 0;
		wt(3); chk("flt", flt, 1'b1);
		chk("lamps", {rl, al}, 2'h1);
		@(posedge clk_i); op <= 0;
		wt(3); chk("flt", flt, 1'b0);
		@(posedge clk_i); frst <= 0; fdet <= 1;
		@(posedge clk_i); fdet <= 0;
		kp.press(1); chk("flt", flt, 1'b0);
		@(posedge clk_i); top <= 1;
		setc(0, 12'h820); kp.press(1); chk("prio", prio, 4'h3);
		@(posedge clk_i); top <= 0;
		setc(1, 12'h801); chk("prio", prio, 4'h5);
		setc(0, 12'h801); chk("prio", prio, 4'h0);
	endtask
	task automatic t_mode;
		@(posedge clk_i); op <= 1;
		for (int i = 1; i <= 7; i++) begin
			kp.press(0); chk("fsel", fsel, 4'(i % 7));
			if (i == 4) begin
				@(posedge clk_i); op <= 0;
				wt(3); chk("pm", pm, 1'b1);
				setc(1, 12'h801); chk("acc", acc, 1'b0);
				@(posedge clk_i); access <= 4'h5;
				wt(3); chk("acc", acc, 1'b1);
				@(posedge clk_i); access <= 4'h0;
			end
		end
		wt(3); chk("pm", pm, 1'b0);
		@(posedge clk_i); edit <= 1;
		wt(3); chk("acc", acc, 1'b0);
		@(posedge clk_i); access <= 4'h5;
		wt(3); chk("acc", acc, 1'b1);
	endtask
	task automatic t_hold;
		@(posedge clk_i); ce_i <= 0; fdet <= 1; cond <= drive_cond_t'(12'h820);
		wt(4); chk("frozen prio", prio, 4'h0);
		chk("frozen flt", flt, 1'b0);
		@(posedge clk_i); fdet <= 0;
		@(posedge clk_i); ce_i <= 1;
		wt(3); chk("prio", prio, 4'h8);
		chk("flt", flt, 1'b0);
		chk("lamps", {rl, al}, 2'h2);
		@(posedge clk_i); fdet <= 1;
		@(posedge clk_i); fdet <= 0;
		wt(2); chk("flt", flt, 1'b1);
		@(posedge clk_i); rst_i <= 1;
		wt(2); chk("rst prio", prio, 4'h1);
		chk("rst outs", {flt, acc, rl, al}, 4'h0);
		@(posedge clk_i); rst_i <= 0;
		wt(2); chk("acc", acc, 1'b1);
		chk("prio", prio, 4'h8);
	endtask
	task automatic complete_run;
		if (mismatches == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#40000;
		mismatches++;
		complete_run;
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		t_prio;
		t_fault;
		t_mode;
		t_hold;
		complete_run;
	end
endmodule
